// [core/lbwrh_local_bus.sv]
module lbwrh_local_bus
  import lbwrh_pkg::*;
#(
  parameter int WAIT_BITS = WAIT_W,
  parameter int REF_BITS = REF_DIV_W
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // CPU side request
  input wire logic req_valid_in,                          // Access request
  input wire logic req_write_in,                          // 1 = write
  input wire logic [lbwrh_pkg::ADDR_W-1:0] req_addr_in,   // Byte address
  input wire logic [lbwrh_pkg::DATA_W-1:0] req_wdata_in,  // Write data
  output logic req_ready_out,                             // Request taken
  output logic rsp_valid_out,                             // Access done pulse
  output logic [lbwrh_pkg::DATA_W-1:0] rsp_rdata_out,     // Read data
  output logic req_range_err_out,                         // Address beyond expansion
  // Configuration bits
  input wire logic [lbwrh_pkg::EXP_W-1:0] expand_step_in, // Expansion step 0..7
  input wire logic [WAIT_BITS*lbwrh_pkg::REGION_CNT-1:0] region_wait_in,
  input wire logic addr_wait_en_in,                       // Global address wait
  input wire logic pulse_refresh_en_in,                   // Periodic refresh cycles
  input wire logic [REF_BITS-1:0] refresh_interval_in,
  input wire logic access_refresh_en_in,                  // Refresh during accesses
  input wire logic [lbwrh_pkg::REGION_W-1:0] refresh_region_in,
  input wire logic standby_in,                            // Standby state
  // External bus
  output logic [lbwrh_pkg::ADDR_W-1:0] addr_out,
  output logic addr_oe_out,
  output logic [lbwrh_pkg::DATA_W-1:0] ad_out,            // Multiplexed address/data
  output logic ad_oe_out,
  input wire logic [lbwrh_pkg::DATA_W-1:0] ad_in,
  output logic address_strobe_out,
  output logic read_strobe_n_out,
  output logic write_strobe_n_out,
  output logic strobe_oe_out,                             // Enable of strobes
  output logic [lbwrh_pkg::REGION_CNT-1:0] region_sel_out,
  output logic refresh_pulse_out_n_out,                   // Refresh request, active low
  input wire logic hold_request_in,
  output logic hold_acknowledge_out,
  output logic busy_out                                   // Cycle in progress
);
  import lbwrh_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Region of an address: top three bits of the 1 MB space
  function automatic logic [REGION_W-1:0] region_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:REGION_LSB];
  endfunction

  // Address fits the expanded external space
  function automatic logic in_range(input logic [ADDR_W-1:0] a, input logic [EXP_W-1:0] s);
    logic [ADDR_W:0] lim;
    lim = (s >= EXP_STEP_MAX) ? (21'h1 << ADDR_W) : (21'h1 << (EXP_MIN_BITS + 2 * s));
    return {1'b0, a} < lim;
  endfunction

  lbwrh_state_t state_ff;            // Bus sequencer state
  lbwrh_state_t nxt_state;
  logic [2:0] cnt_ff;                // Phase counter
  logic [2:0] nxt_cnt;
  logic wr_ff;                       // Current access is a write
  logic [ADDR_W-1:0] addr_ff;        // Latched address
  logic [DATA_W-1:0] wdata_ff;
  logic [REGION_W-1:0] reg_ff;       // Latched region
  logic [WAIT_BITS-1:0] wait_sel;    // Wait count of the latched region
  logic refresh_due;                 // Interval timer request
  logic refresh_take;                // Refresh cycle started
  logic accept;                      // New access accepted
  logic hold_ok;                     // Hold may be granted now
  logic strobe_end;                  // Last strobe cycle
  logic addr_end;                    // Last address cycle
  logic [2:0] addr_len;              // Address phase length

  // ----------------------------------------
  // Refresh interval timer
  // ----------------------------------------
  lbwrh_refresh_timer #(.DIV_W(REF_BITS)) u_timer (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .run_in(pulse_refresh_en_in && (state_ff != LBWRH_HOLD) && !standby_in),
    .interval_in(refresh_interval_in),
    .taken_in(refresh_take),
    .due_out(refresh_due)
  );

  // ----------------------------------------
  // Sequencer decode
  // ----------------------------------------
  assign wait_sel = region_wait_in[reg_ff*WAIT_BITS +: WAIT_BITS];
  assign addr_len = 3'(ADDR_PHASE_CYC) + (addr_wait_en_in ? 3'(ADDR_WAIT_CYC) : 3'h0);
  assign addr_end = (cnt_ff + 3'h1 >= addr_len);
  assign strobe_end = (cnt_ff >= 3'(wait_sel));
  // Hold only granted between cycles, so the running cycle always finishes
  assign hold_ok = (state_ff == LBWRH_IDLE) && hold_request_in;
  assign refresh_take = (state_ff == LBWRH_IDLE) && !hold_request_in && refresh_due && !standby_in;
  assign accept = (state_ff == LBWRH_IDLE) && !hold_request_in && !refresh_take && !standby_in
                  && req_valid_in && in_range(req_addr_in, expand_step_in);
  assign req_ready_out = accept
                         || ((state_ff == LBWRH_IDLE) && !hold_request_in && !refresh_take && !standby_in
                             && req_valid_in && !in_range(req_addr_in, expand_step_in));
  assign req_range_err_out = req_ready_out && !accept;
  assign busy_out = (state_ff == LBWRH_ADDR) || (state_ff == LBWRH_STRB) || (state_ff == LBWRH_REFR);

  // Next-state logic
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      LBWRH_IDLE: begin
        nxt_cnt = 3'h0;
        if (hold_ok) begin
          nxt_state = LBWRH_HOLD;
        end else if (refresh_take) begin
          nxt_state = LBWRH_REFR;
        end else if (accept) begin
          nxt_state = LBWRH_ADDR;
        end
      end
      LBWRH_ADDR: begin
        if (addr_end) begin
          nxt_state = LBWRH_STRB;
          nxt_cnt = 3'h0;
        end else begin
          nxt_cnt = cnt_ff + 3'h1;
        end
      end
      LBWRH_STRB: begin
        if (strobe_end) begin
          nxt_state = LBWRH_IDLE;
          nxt_cnt = 3'h0;
        end else begin
          nxt_cnt = cnt_ff + 3'h1;
        end
      end
      LBWRH_REFR: begin
        nxt_state = LBWRH_IDLE;  // Single-cycle refresh bus cycle
      end
      LBWRH_HOLD: begin
        if (!hold_request_in) begin
          nxt_state = LBWRH_IDLE;
        end
      end
      default: begin
        nxt_state = LBWRH_IDLE;
        nxt_cnt = 3'h0;
      end
    endcase
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= LBWRH_IDLE;
      cnt_ff <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // Access latch, loaded when a request is accepted
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ff <= 1'b0;
      addr_ff <= '0;
      wdata_ff <= '0;
      reg_ff <= '0;
    end else if (accept) begin
      wr_ff <= req_write_in;
      addr_ff <= req_addr_in;
      wdata_ff <= req_wdata_in;
      reg_ff <= region_of(req_addr_in);
    end
  end

  // ----------------------------------------
  // Bus pins
  // ----------------------------------------
  // Registered outputs; driven from the next state so pins settle with the state
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      addr_out <= '0;
      ad_out <= '0;
      ad_oe_out <= 1'b0;
      address_strobe_out <= 1'b0;
      read_strobe_n_out <= 1'b1;
      write_strobe_n_out <= 1'b1;
      region_sel_out <= '0;
    end else begin
      address_strobe_out <= (nxt_state == LBWRH_ADDR);
      read_strobe_n_out <= !((nxt_state == LBWRH_STRB) && !wr_ff);
      write_strobe_n_out <= !((nxt_state == LBWRH_STRB) && wr_ff);
      if (state_ff == LBWRH_IDLE && accept) begin
        addr_out <= req_addr_in;
        ad_out <= req_addr_in[DATA_W-1:0];  // Low address on the shared lines
        ad_oe_out <= 1'b1;
        region_sel_out <= REGION_CNT'(1) << region_of(req_addr_in);
      end else if (nxt_state == LBWRH_STRB) begin
        ad_out <= wdata_ff;
        ad_oe_out <= wr_ff;  // Released for reads so memory can drive
      end else if (nxt_state != LBWRH_ADDR) begin
        ad_oe_out <= 1'b0;
        region_sel_out <= '0;
      end
    end
  end

  // Address and strobe drivers float only while the other master owns the bus
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      addr_oe_out <= 1'b1;
      strobe_oe_out <= 1'b1;
      hold_acknowledge_out <= 1'b0;
    end else begin
      addr_oe_out <= (nxt_state != LBWRH_HOLD);
      strobe_oe_out <= (nxt_state != LBWRH_HOLD);
      // Acknowledge follows one cycle after the drivers let go
      hold_acknowledge_out <= (state_ff == LBWRH_HOLD) && (nxt_state == LBWRH_HOLD);
    end
  end

  // Refresh output: low level in standby unless held, one-cycle pulse otherwise
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      refresh_pulse_out_n_out <= 1'b1;
    end else if (standby_in && state_ff != LBWRH_HOLD) begin
      refresh_pulse_out_n_out <= 1'b0;
    end else if (nxt_state == LBWRH_REFR) begin
      refresh_pulse_out_n_out <= 1'b0;
    end else if (access_refresh_en_in && accept && region_of(req_addr_in) == refresh_region_in) begin
      refresh_pulse_out_n_out <= 1'b0;
    end else begin
      refresh_pulse_out_n_out <= 1'b1;
    end
  end

  // Read data capture and completion pulse
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= '0;
    end else begin
      rsp_valid_out <= (state_ff == LBWRH_STRB) && strobe_end;
      if ((state_ff == LBWRH_STRB) && strobe_end && !wr_ff) begin
        rsp_rdata_out <= ad_in;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  hold_after_float_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    hold_acknowledge_out |-> !addr_oe_out && !strobe_oe_out && !ad_oe_out)
    else $error("Acknowledge while bus still driven");
  ack_delay_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state_ff == LBWRH_IDLE && hold_request_in) |-> ##2 hold_acknowledge_out || !hold_request_in)
    else $error("Acknowledge late");
  no_cycle_hold_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    busy_out |-> !hold_acknowledge_out)
    else $error("Acknowledge during bus cycle");
  hold_quiet_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    hold_acknowledge_out && !standby_in |-> refresh_pulse_out_n_out && read_strobe_n_out)
    else $error("Activity while held");
  release_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $fell(hold_request_in) && hold_acknowledge_out |=> !hold_acknowledge_out ##1 addr_oe_out)
    else $error("Release mishandled");
  standby_low_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    standby_in && state_ff != LBWRH_HOLD |=> !refresh_pulse_out_n_out)
    else $error("Refresh not low in standby");
  refr_pulse_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    refresh_take |=> !refresh_pulse_out_n_out && state_ff == LBWRH_REFR)
    else $error("Refresh cycle missing pulse");
  addr_wait_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    accept && addr_wait_en_in |=> address_strobe_out [*2])
    else $error("Address wait not applied");
  strobe_len_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $fell(read_strobe_n_out) && wait_sel == '0 |=> read_strobe_n_out)
    else $error("Strobe length wrong");
  access_refr_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    accept && access_refresh_en_in && region_of(req_addr_in) == refresh_region_in
    |=> !refresh_pulse_out_n_out)
    else $error("Access refresh pulse missing");
  cov_read_c: cover property (@(posedge ref_clk_in) accept && !req_write_in);
  cov_write_c: cover property (@(posedge ref_clk_in) accept && req_write_in);
  cov_hold_c: cover property (@(posedge ref_clk_in) $rose(hold_acknowledge_out));
  cov_refr_c: cover property (@(posedge ref_clk_in) refresh_take);
endmodule

// [core/lbwrh_pkg.sv]
package lbwrh_pkg;
  // ----------------------------------------
  // Address space layout
  // ----------------------------------------
  localparam int ADDR_W = 20;                  // One megabyte of external space
  localparam int REGION_W = 3;                 // Eight regions
  localparam int REGION_CNT = 8;
  localparam int REGION_LSB = 17;              // Region picked by the top three address bits
  localparam int EXP_W = 3;                    // Expansion setting field width
  localparam logic [2:0] EXP_STEP_MAX = 3'h7;  // Highest of eight expansion steps
  localparam int EXP_MIN_BITS = 8;             // Smallest step is 256 bytes
  localparam int DATA_W = 8;
  localparam int WAIT_W = 2;                   // Per-region wait count width
  localparam int REF_DIV_W = 8;                // Refresh interval counter width
  // ----------------------------------------
  // Timing constants
  // ----------------------------------------
  localparam int ADDR_PHASE_CYC = 1;           // Base address strobe phase
  localparam int ADDR_WAIT_CYC = 1;            // Extra phase when address wait is on
  localparam logic [7:0] REF_INTERVAL_RST = 8'h40;  // Default refresh interval
  localparam logic [WAIT_W*REGION_CNT-1:0] WAIT_RST = 16'h0000;
  // ----------------------------------------
  // Bus sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    LBWRH_IDLE,
    LBWRH_ADDR,
    LBWRH_STRB,
    LBWRH_REFR,
    LBWRH_HOLD
  } lbwrh_state_t;
endpackage

// [core/lbwrh_refresh_timer.sv]
// Refresh interval timer that counts only while run_in is high; raises a due flag and
// keeps it pending until the sequencer takes it.
module lbwrh_refresh_timer
  import lbwrh_pkg::*;
#(
  parameter int DIV_W = REF_DIV_W
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic run_in,                   // Counting allowed
  input wire logic [DIV_W-1:0] interval_in,  // Cycles between requests
  input wire logic taken_in,                 // Sequencer served the request
  output logic due_out                       // Refresh request pending
);
  logic [DIV_W-1:0] cnt_ff;  // Cycles since last request
  logic [DIV_W-1:0] nxt_cnt;
  logic expire;              // Interval elapsed

  // ----------------------------------------
  // Interval counter
  // ----------------------------------------
  assign expire = run_in && (cnt_ff >= interval_in);
  assign nxt_cnt = expire ? '0 : (run_in ? cnt_ff + 1'b1 : cnt_ff);

  // Counter holds still while suspended so no refresh piles up
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Pending flag: a new expiry wins over a take in the same cycle
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      due_out <= 1'b0;
    end else if (expire) begin
      due_out <= 1'b1;
    end else if (taken_in) begin
      due_out <= 1'b0;
    end
  end
endmodule

// [testbench/lbwrh_far_side.sv]
// Far side: byte memory with a pattern fill, plus an external bus master
module lbwrh_far_side
  import lbwrh_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic [lbwrh_pkg::ADDR_W-1:0] addr_in,
  input wire logic [lbwrh_pkg::DATA_W-1:0] wdata_in,
  input wire logic read_n_in,
  input wire logic write_n_in,
  input wire logic strobe_oe_in,
  input wire logic want_in,
  output logic [lbwrh_pkg::DATA_W-1:0] rdata_out,
  output logic hold_req_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Cells written so far; others read a fixed pattern
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic want_q;  // Wish of the master, taken at the edge so it never races the bench
  initial begin
    rdata_out = 8'h5A;
    hold_req_out = 1'b0;
  end
  // ----------------------------------------
  // Memory and master behaviour
  // ----------------------------------------
  always @(posedge ref_clk_in) begin
    if (strobe_oe_in && !write_n_in) begin
      mem[addr_in] = wdata_in;
    end
    want_q = want_in;
    #5;
    // Released lines toggle so a late sample never matches by luck
    if (strobe_oe_in && !read_n_in) begin
      rdata_out = mem.exists(addr_in) ? mem[addr_in] : (addr_in[7:0] ^ addr_in[19:12]);
    end else begin
      rdata_out = ~rdata_out;
    end
    // Request kept up until the master is done with the bus
    hold_req_out = want_q;
  end
endmodule

// [testbench/local_bus_wait_refresh_hold_bench.sv]
module local_bus_wait_refresh_hold_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import lbwrh_pkg::*;
  logic ref_clk_in, rst_in, req_valid_in, req_write_in, req_ready_out, rsp_valid_out, req_range_err_out;
  logic [ADDR_W-1:0] req_addr_in, addr_out;
  logic [DATA_W-1:0] req_wdata_in, ad_in, far_data, rsp_rdata_out, ad_out;
  logic [EXP_W-1:0] expand_step_in;
  logic [2*REGION_CNT-1:0] region_wait_in;
  logic addr_wait_en_in, pulse_refresh_en_in, access_refresh_en_in, standby_in, hold_request_in;
  logic [7:0] refresh_interval_in;
  logic [2:0] refresh_region_in;
  logic addr_oe_out, ad_oe_out, address_strobe_out, read_strobe_n_out, write_strobe_n_out, strobe_oe_out;
  logic refresh_pulse_out_n_out, hold_acknowledge_out, busy_out, want, hold_mid;
  logic [REGION_CNT-1:0] region_sel_out;
  int n_mismatch, comparisons, cyc, seed, i, k, na, ns, nr, no;
  logic [7:0] shadow [logic [19:0]];
  logic [19:0] a;
  // Data wire: the design wins while it drives
  assign ad_in = ad_oe_out ? ad_out : far_data;

  lbwrh_local_bus i_dut (.ref_clk_in, .rst_in, .req_valid_in, .req_write_in, .req_addr_in, .req_wdata_in,
    .req_ready_out, .rsp_valid_out, .rsp_rdata_out, .req_range_err_out, .expand_step_in, .region_wait_in,
    .addr_wait_en_in, .pulse_refresh_en_in, .refresh_interval_in, .access_refresh_en_in, .refresh_region_in,
    .standby_in, .addr_out, .addr_oe_out, .ad_out, .ad_oe_out, .ad_in, .address_strobe_out,
    .read_strobe_n_out, .write_strobe_n_out, .strobe_oe_out, .region_sel_out, .refresh_pulse_out_n_out,
    .hold_request_in, .hold_acknowledge_out, .busy_out);
  lbwrh_far_side i_far (.ref_clk_in, .addr_in(addr_out), .wdata_in(ad_out), .read_n_in(read_strobe_n_out),
    .write_n_in(write_strobe_n_out), .strobe_oe_in(strobe_oe_out), .want_in(want), .rdata_out(far_data),
    .hold_req_out(hold_request_in));

  // ----------------------------------------
  // Clock, timeout, reporting
  // ----------------------------------------
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  // Whole run needs about 1000 cycles; the ceiling leaves wide margin
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Idle watch: counts refresh lows, back-to-back lows, ready and enables
  task automatic watch(input int n);
    logic prev;
    prev = 1'b1;
    nr = 0;
    ns = 0;
    na = 0;
    no = 0;
    repeat (n) begin
      @(posedge ref_clk_in);
      #1;
      na += req_ready_out;
      nr += !refresh_pulse_out_n_out;
      ns += !prev && !refresh_pulse_out_n_out;
      no += addr_oe_out | ad_oe_out | strobe_oe_out;
      prev = refresh_pulse_out_n_out;
    end
    #4;
  endtask
  // ----------------------------------------
  // One access, checked cycle by cycle
  // ----------------------------------------
  task automatic access(input logic w, input logic [19:0] ad, input logic [7:0] d);
    logic [2:0] r;
    logic [1:0] ws;
    logic err;
    r = ad[19:17];
    ws = region_wait_in[2*r +: 2];
    err = (ad >= (1 << (8 + 2 * expand_step_in)));
    req_write_in = w;
    req_addr_in = ad;
    req_wdata_in = d;
    req_valid_in = 1'b1;
    k = 0;
    #1;
    // Ready is combinational: look at it settled, well before the edge that takes it
    while (req_ready_out !== 1'b1 && k < 60) begin
      @(posedge ref_clk_in);
      #6;
      k++;
    end
    chk("ready", 1, k < 60);
    chk("range_err", err, req_range_err_out);
    @(posedge ref_clk_in);
    na = 0;
    ns = 0;
    for (k = 1; k < 12; k++) begin
      #1;
      na += address_strobe_out;
      ns += !read_strobe_n_out || !write_strobe_n_out;
      if (k == 1) begin
        chk("refresh_acc", !(access_refresh_en_in && r == refresh_region_in && !err), refresh_pulse_out_n_out);
        if (!err) chk("region_sel", 8'h1 << r, region_sel_out);
        if (!err) chk("addr_out", ad, addr_out);
        if (!err) chk("ad_phase", {1'b1, ad[7:0]}, {ad_oe_out, ad_out});
        chk("busy", !err, busy_out);
        #4 req_valid_in = 1'b0;
        if (hold_mid) want = 1'b1;
      end
      if (rsp_valid_out === 1'b1) break;
      @(posedge ref_clk_in);
    end
    if (err) begin
      chk("no_cycle", 0, na + ns);
    end else begin
      chk("latency", 3 + addr_wait_en_in + ws, k);
      chk("address_strobe_len", 1 + addr_wait_en_in, na);
      chk("strobe_len", 1 + ws, ns);
      if (w) shadow[ad] = d;
      else chk("rdata", shadow.exists(ad) ? shadow[ad] : ad[7:0] ^ ad[19:12], rsp_rdata_out);
    end
    @(posedge ref_clk_in);
    #5;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h2E9D;
    {rst_in, req_valid_in, req_write_in, req_addr_in, req_wdata_in} = 31'h40000000;
    {expand_step_in, region_wait_in, addr_wait_en_in, pulse_refresh_en_in} = 21'h000000;
    {refresh_interval_in, access_refresh_en_in, refresh_region_in, standby_in} = 13'h100;
    {want, hold_mid} = 2'h0;
    repeat (2) @(posedge ref_clk_in);
    #1 chk("reset_outs", 9'h1B2, {read_strobe_n_out, write_strobe_n_out, address_strobe_out, addr_oe_out,
      strobe_oe_out, ad_oe_out, hold_acknowledge_out, refresh_pulse_out_n_out, rsp_valid_out});
    repeat (2) @(posedge ref_clk_in);
    #5 rst_in = 1'b0;
    // Corners: range boundary, longest waits, top of space
    region_wait_in = 16'hC000;
    addr_wait_en_in = 1'b1;
    access(1, 20'h000FF, 8'hA5);
    access(1, 20'h00100, 8'h3C);
    expand_step_in = 3'h7;
    access(1, 20'hFFFFF, 8'hC3);
    access(0, 20'hFFFFF, 8'h00);
    for (i = 0; i < 90; i++) begin
      region_wait_in = 16'($random(seed));
      addr_wait_en_in = 1'($random(seed));
      access_refresh_en_in = 1'($random(seed));
      refresh_region_in = 3'($random(seed));
      expand_step_in = (i < 45) ? 3'($random(seed)) : 3'h7;
      a = 20'($random(seed)) & 20'hE010F;
      access(1'($random(seed)), a, 8'($random(seed)));
    end
    access_refresh_en_in = 1'b0;
    pulse_refresh_en_in = 1'b1;
    watch(72);
    chk("pulse_count", 1, nr >= 7 && nr <= 9);
    chk("pulse_width", 0, ns);
    standby_in = 1'b1;
    req_valid_in = 1'b1;
    watch(4);
    watch(20);
    chk("standby_low", 20, nr);
    chk("standby_ready", 0, na);
    {standby_in, req_valid_in, pulse_refresh_en_in} = 3'h0;
    watch(3);
    hold_mid = 1'b1;
    access(0, 20'h20004, 8'h00);
    hold_mid = 1'b0;
    for (k = 0; k < 10 && hold_acknowledge_out !== 1'b1; k++) begin
      @(posedge ref_clk_in);
      #1;
    end
    chk("ack_rise", 1, k < 10);
    chk("bus_float", 0, {addr_oe_out, ad_oe_out, strobe_oe_out});
    #4 {pulse_refresh_en_in, req_valid_in} = 2'h3;
    watch(30);
    chk("held_refresh", 0, nr);
    chk("held_float", 0, no + na);
    req_valid_in = 1'b0;
    want = 1'b0;
    watch(4);
    chk("ack_fall", 0, hold_acknowledge_out);
    chk("bus_back", 2'h3, {addr_oe_out, strobe_oe_out});
    watch(30);
    chk("refresh_back", 1, nr > 0);
    pulse_refresh_en_in = 1'b0;
    watch(3);
    access(1, 20'h40010, 8'h96);
    access(0, 20'h40010, 8'h00);
    wrap_up();
  end
endmodule
